// ### verilog/cdoc_defs.svh
// offsets, field positions, mode codes, widths and response codes for the dead-band output block
`ifndef CDOC_DEFS_SVH
`define CDOC_DEFS_SVH

`define CDOC_ADDR_W 8
`define CDOC_OFS_CTRL 8'h00
`define CDOC_OFS_POLARITY 8'h04
`define CDOC_OFS_SOURCE 8'h08
`define CDOC_OFS_CLKSEL 8'h0c
`define CDOC_OFS_DB_RISE 8'h10
`define CDOC_OFS_DB_FALL 8'h14
`define CDOC_OFS_OVERRIDE 8'h18
`define CDOC_OFS_STATUS 8'h1c

`define CDOC_CTRL_EN_BIT 7
`define CDOC_CTRL_LD_BIT 6

`define CDOC_MODE_ASYNC_STEER 3'h0
`define CDOC_MODE_SYNC_STEER 3'h1
`define CDOC_MODE_FWD 3'h2
`define CDOC_MODE_REV 3'h3
`define CDOC_MODE_HALF 3'h4
`define CDOC_MODE_PUSH_PULL 3'h5

`define CDOC_SRC_COUNT 14
`define CDOC_DB_W 6
`define CDOC_OSC_MHZ 16

`define CDOC_RESP_OKAY 2'h0
`define CDOC_RESP_DECERR 2'h3

`endif

// ### verilog/cdoc_pkg.sv
// types of the dead-band output block
`include "cdoc_defs.svh"
package cdoc_pkg;

	typedef enum logic [2:0]
	{
		LD_IDLE = 3'h1,
		LD_WAIT_FALL = 3'h2,
		LD_WAIT_RISE = 3'h4
	} cdoc_ld_e;

	typedef logic [`CDOC_DB_W-1:0] cdoc_count_t;

	typedef struct packed
	{
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_got;
		logic [`CDOC_ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [7:0] wbyte;
		logic wlane0;
		logic en;
		logic [2:0] mode;
		logic [3:0] pol;
		logic [3:0] src_sel;
		logic clk_sel;
		cdoc_count_t dbr_buf;
		cdoc_count_t dbf_buf;
		cdoc_count_t dbr_act;
		cdoc_count_t dbf_act;
		logic [3:0] ovr;
		cdoc_ld_e ld_state;
		logic din_q;
		logic osc_q;
		logic rise_busy;
		cdoc_count_t rise_cnt;
		logic fall_busy;
		cdoc_count_t fall_cnt;
		logic dir_rev;
		logic pp_phase;
		logic armed;
		logic [3:0] outs;
		logic osc_run;
	} cdoc_state_s;

endpackage

// ### verilog/cdoc_top.sv
// dead-band, polarity and source selection core with AXI4-Lite registers
//
// Notes on behaviour
// - dead-band counting uses the system clock or the fast oscillator, one select bit.
// - with the oscillator selected and the block enabled, it is requested to run through sleep.
// - a four-bit field picks the data input from fourteen peripheral signals.
// - right after enable all outputs are held inactive.
// - each output has a polarity bit; set means active-low.
// - override levels bypass the polarity inversion and drive as configured.
// - two independent 6-bit counters time rising and falling dead bands.
// - dead band only in half-bridge and full-bridge modes.
// - a dead band counts up from zero on each dead-band clock tick.
// - half-bridge, output A turn-on waits the rising count after a rise.
// - half-bridge, output B turn-on waits the falling count after a fall.
// - full-bridge forward to reverse delays new modulated output B by rising count.
// - full-bridge reverse to forward delays new modulated output D by falling count.
// - each dead band spans zero to 64 ticks; zero inserts no delay.
// - every dead band starts at an edge of the data input.
// - an input edge during a running count drops the pending turn-on.
// - counts are double-buffered; writes while disabled load the active copy.
// - enabled, the load request moves counts at the rise after the next fall.
// - an asynchronous input may lengthen a dead band by one tick at most.
// - half-bridge drives A as input copy, B as inverted copy.
// - forward mode drives A active, modulates D, holds B and C inactive.
// - reverse mode drives C active, modulates B, holds A and D inactive.
`timescale 1ns/1ps
`default_nettype none
`include "cdoc_defs.svh"

module cdoc_top
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`CDOC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`CDOC_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [`CDOC_SRC_COUNT-1:0] peripheral_sources,
	input wire logic internal_fast_oscillator,
	input wire logic shutdown_active,
	output logic output_a,
	output logic output_b,
	output logic output_c,
	output logic output_d,
	output logic osc_run_request
);

	cdoc_pkg::cdoc_state_s state_reg;
	cdoc_pkg::cdoc_state_s state_next;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic cdoc_pkg::cdoc_count_t inc_count
	(
		input cdoc_pkg::cdoc_count_t v
	);
		inc_count = v + 6'h01;
	endfunction

	function automatic logic pick_source
	(
		input logic [`CDOC_SRC_COUNT-1:0] srcs,
		input logic [3:0] sel
	);
		if (sel < 4'he)
		begin
			pick_source = srcs[sel];
		end
		else
		begin
			pick_source = 1'b0;
		end
	endfunction

	function automatic logic is_mapped
	(
		input logic [`CDOC_ADDR_W-1:0] a
	);
		is_mapped = (a[1:0] == 2'h0) && (a <= `CDOC_OFS_STATUS);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// combinational next state

	logic din;
	logic tick;
	logic rise;
	logic fall;
	logic half;
	logic full;
	logic want_rev;
	logic [3:0] raw;
	logic do_write;
	logic en_rise;

	always_comb
	begin
		state_next = state_reg;
		raw = 4'h0;
		din = pick_source(peripheral_sources, state_reg.src_sel);
		state_next.din_q = din;
		state_next.osc_q = internal_fast_oscillator;
		// oscillator edge or every system clock
		tick = state_reg.clk_sel ? (internal_fast_oscillator & ~state_reg.osc_q)
			: 1'b1;
		rise = din & ~state_reg.din_q;
		fall = ~din & state_reg.din_q;
		half = state_reg.mode == `CDOC_MODE_HALF;
		full = (state_reg.mode == `CDOC_MODE_FWD)
			|| (state_reg.mode == `CDOC_MODE_REV);
		want_rev = state_reg.mode == `CDOC_MODE_REV;
		do_write = 1'b0;
		en_rise = 1'b0;

		// count ticks from zero up to the active value
		if (state_reg.rise_busy && tick)
		begin
			if (state_reg.rise_cnt == state_reg.dbr_act)
			begin
				state_next.rise_busy = 1'b0;
			end
			else
			begin
				state_next.rise_cnt = inc_count(state_reg.rise_cnt);
			end
		end
		if (state_reg.fall_busy && tick)
		begin
			if (state_reg.fall_cnt == state_reg.dbf_act)
			begin
				state_next.fall_busy = 1'b0;
			end
			else
			begin
				state_next.fall_cnt = inc_count(state_reg.fall_cnt);
			end
		end

		// an edge drops any pending turn-on
		if (rise || fall)
		begin
			state_next.rise_busy = 1'b0;
			state_next.fall_busy = 1'b0;
			state_next.armed = 1'b1;
		end

		if (half)
		begin
			if (rise && (state_reg.dbr_act != 6'h00))
			begin
				state_next.rise_busy = 1'b1;
				state_next.rise_cnt = 6'h00;
			end
			if (fall && (state_reg.dbf_act != 6'h00))
			begin
				state_next.fall_busy = 1'b1;
				state_next.fall_cnt = 6'h00;
			end
		end
		else if (full && rise && (want_rev != state_reg.dir_rev))
		begin
			state_next.dir_rev = want_rev;
			if (want_rev && (state_reg.dbr_act != 6'h00))
			begin
				state_next.rise_busy = 1'b1;
				state_next.rise_cnt = 6'h00;
			end
			else if (!want_rev && (state_reg.dbf_act != 6'h00))
			begin
				state_next.fall_busy = 1'b1;
				state_next.fall_cnt = 6'h00;
			end
		end

		if (rise && (state_reg.mode == `CDOC_MODE_PUSH_PULL))
		begin
			state_next.pp_phase = ~state_reg.pp_phase;
		end

		// deferred load of the active counts
		unique case (state_reg.ld_state)
			cdoc_pkg::LD_IDLE:
			begin
			end
			cdoc_pkg::LD_WAIT_FALL:
			begin
				if (fall)
				begin
					state_next.ld_state = cdoc_pkg::LD_WAIT_RISE;
				end
			end
			cdoc_pkg::LD_WAIT_RISE:
			begin
				if (rise)
				begin
					state_next.dbr_act = state_reg.dbr_buf;
					state_next.dbf_act = state_reg.dbf_buf;
					state_next.ld_state = cdoc_pkg::LD_IDLE;
				end
			end
		endcase

		////////////////////////////////////////////////////////////////
		// AXI4-Lite write channel

		if (s_axi_awvalid && state_reg.awready)
		begin
			state_next.aw_got = 1'b1;
			state_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && state_reg.wready)
		begin
			state_next.w_got = 1'b1;
			state_next.wbyte = s_axi_wdata[7:0];
			state_next.wlane0 = s_axi_wstrb[0];
		end
		if (state_reg.bvalid && s_axi_bready)
		begin
			state_next.bvalid = 1'b0;
		end
		if (state_next.aw_got && state_next.w_got && !state_reg.bvalid)
		begin
			do_write = 1'b1;
			state_next.aw_got = 1'b0;
			state_next.w_got = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = is_mapped(state_next.aw_addr)
				? `CDOC_RESP_OKAY : `CDOC_RESP_DECERR;
		end
		if (do_write && state_next.wlane0)
		begin
			unique case (state_next.aw_addr)
				`CDOC_OFS_CTRL:
				begin
					en_rise = state_next.wbyte[`CDOC_CTRL_EN_BIT] & ~state_reg.en;
					state_next.en = state_next.wbyte[`CDOC_CTRL_EN_BIT];
					state_next.mode = state_next.wbyte[2:0];
					// a new request wins over a same-cycle completion
					if (state_reg.en && state_next.wbyte[`CDOC_CTRL_LD_BIT])
					begin
						state_next.ld_state = cdoc_pkg::LD_WAIT_FALL;
					end
				end
				`CDOC_OFS_POLARITY:
				begin
					state_next.pol = state_next.wbyte[3:0];
				end
				`CDOC_OFS_SOURCE:
				begin
					state_next.src_sel = state_next.wbyte[3:0];
				end
				`CDOC_OFS_CLKSEL:
				begin
					state_next.clk_sel = state_next.wbyte[0];
				end
				`CDOC_OFS_DB_RISE:
				begin
					state_next.dbr_buf = state_next.wbyte[5:0];
					if (!state_reg.en)
					begin
						state_next.dbr_act = state_next.wbyte[5:0];
					end
				end
				`CDOC_OFS_DB_FALL:
				begin
					state_next.dbf_buf = state_next.wbyte[5:0];
					if (!state_reg.en)
					begin
						state_next.dbf_act = state_next.wbyte[5:0];
					end
				end
				`CDOC_OFS_OVERRIDE:
				begin
					state_next.ovr = state_next.wbyte[3:0];
				end
				default:
				begin
				end
			endcase
		end
		state_next.awready = ~state_next.aw_got & ~state_next.bvalid;
		state_next.wready = ~state_next.w_got & ~state_next.bvalid;

		////////////////////////////////////////////////////////////////
		// AXI4-Lite read channel

		if (state_reg.rvalid && s_axi_rready)
		begin
			state_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && state_reg.arready)
		begin
			state_next.rvalid = 1'b1;
			state_next.rdata = 32'h0;
			state_next.rresp = is_mapped(s_axi_araddr)
				? `CDOC_RESP_OKAY : `CDOC_RESP_DECERR;
			unique case (s_axi_araddr)
				`CDOC_OFS_CTRL:
				begin
					state_next.rdata[`CDOC_CTRL_EN_BIT] = state_reg.en;
					state_next.rdata[`CDOC_CTRL_LD_BIT] =
						state_reg.ld_state != cdoc_pkg::LD_IDLE;
					state_next.rdata[2:0] = state_reg.mode;
				end
				`CDOC_OFS_POLARITY:
				begin
					state_next.rdata[3:0] = state_reg.pol;
				end
				`CDOC_OFS_SOURCE:
				begin
					state_next.rdata[3:0] = state_reg.src_sel;
				end
				`CDOC_OFS_CLKSEL:
				begin
					state_next.rdata[0] = state_reg.clk_sel;
				end
				`CDOC_OFS_DB_RISE:
				begin
					state_next.rdata[5:0] = state_reg.dbr_buf;
				end
				`CDOC_OFS_DB_FALL:
				begin
					state_next.rdata[5:0] = state_reg.dbf_buf;
				end
				`CDOC_OFS_OVERRIDE:
				begin
					state_next.rdata[3:0] = state_reg.ovr;
				end
				`CDOC_OFS_STATUS:
				begin
					state_next.rdata[3:0] = state_reg.outs;
					state_next.rdata[4] = state_reg.din_q;
					state_next.rdata[5] = state_reg.rise_busy;
					state_next.rdata[6] = state_reg.fall_busy;
					state_next.rdata[7] = state_reg.dir_rev;
				end
				default:
				begin
				end
			endcase
		end
		state_next.arready = ~state_next.rvalid;

		////////////////////////////////////////////////////////////////
		// enable handling and output shaping

		if (en_rise || !state_next.en)
		begin
			// start clean; first edge arms the drive
			state_next.armed = 1'b0;
			state_next.rise_busy = 1'b0;
			state_next.fall_busy = 1'b0;
			state_next.pp_phase = 1'b0;
			state_next.dir_rev = state_next.mode == `CDOC_MODE_REV;
			state_next.ld_state = cdoc_pkg::LD_IDLE;
		end

		unique case (state_next.mode)
			`CDOC_MODE_HALF:
			begin
				raw[0] = din & ~state_next.rise_busy;
				raw[1] = ~din & ~state_next.fall_busy;
				raw[2] = raw[0];
				raw[3] = raw[1];
			end
			`CDOC_MODE_FWD, `CDOC_MODE_REV:
			begin
				if (state_next.dir_rev)
				begin
					raw[2] = 1'b1;
					raw[1] = din & ~state_next.rise_busy;
				end
				else
				begin
					raw[0] = 1'b1;
					raw[3] = din & ~state_next.fall_busy;
				end
			end
			`CDOC_MODE_PUSH_PULL:
			begin
				raw[0] = din & state_next.pp_phase;
				raw[1] = din & ~state_next.pp_phase;
				raw[2] = raw[0];
				raw[3] = raw[1];
			end
			`CDOC_MODE_ASYNC_STEER, `CDOC_MODE_SYNC_STEER:
			begin
				raw = {4{din}};
			end
			default:
			begin
				raw = 4'h0;
			end
		endcase
		if (!state_next.en || !state_next.armed)
		begin
			raw = 4'h0;
		end

		if (shutdown_active)
		begin
			state_next.outs = state_next.ovr;
		end
		else
		begin
			state_next.outs = raw ^ state_next.pol;
		end
		state_next.osc_run = state_next.en & state_next.clk_sel;
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= '0;
			state_reg.ld_state <= cdoc_pkg::LD_IDLE;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign s_axi_awready = state_reg.awready;
	assign s_axi_wready = state_reg.wready;
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_arready = state_reg.arready;
	assign s_axi_rvalid = state_reg.rvalid;
	assign s_axi_rresp = state_reg.rresp;
	assign s_axi_rdata = state_reg.rdata;
	assign output_a = state_reg.outs[0];
	assign output_b = state_reg.outs[1];
	assign output_c = state_reg.outs[2];
	assign output_d = state_reg.outs[3];
	assign osc_run_request = state_reg.osc_run;

endmodule
`default_nettype wire

// ### sim/cdoc_top_asserts.sv
// bus and pin assertions for the dead-band output block
`timescale 1ns/1ps
`default_nettype none
module cdoc_top_asserts
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic shutdown_active,
	input wire logic output_a,
	input wire logic output_b,
	input wire logic output_c,
	input wire logic output_d
);
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
	chk_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("no rvalid");
	chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready during rvalid");
	chk_aw_block: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready) else $error("ready during bvalid");
	chk_rdata_top: assert property (s_axi_rvalid |->
		s_axi_rdata[31:8] == 24'h0) else $error("rdata upper bits set");
	chk_ovr_steady: assert property (shutdown_active [*3] |->
		$stable({output_d, output_c, output_b, output_a}))
		else $error("outputs moved under override");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (shutdown_active [*3]);
endmodule
bind cdoc_top cdoc_top_asserts cdoc_top_asserts_inst
(
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .shutdown_active, .output_a, .output_b, .output_c,
	.output_d
);
`default_nettype wire

// ### sim/cdoc_switch_model.sv
// one bridge leg of power switches, counting shoot-through cycles
`timescale 1ns/1ps
`default_nettype none
module cdoc_switch_model
(
	input wire logic aclk,
	input wire logic high_side,
	input wire logic low_side,
	output logic [15:0] overlap_cnt
);
	initial overlap_cnt = 16'h0;
	// both switches of the leg conducting
	always @(posedge aclk)
		if (high_side && low_side)
			overlap_cnt <= overlap_cnt + 16'h1;
endmodule
`default_nettype wire

// ### sim/tb_cdoc_top.sv
// self-checking bench for the dead-band output block
`timescale 1ns/1ps
`default_nettype none
`include "cdoc_defs.svh"
module tb_cdoc_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0;
	logic [2:0] s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [13:0] peripheral_sources = 14'h0;
	logic internal_fast_oscillator = 1'b0;
	logic shutdown_active = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, output_a, output_b, output_c, output_d;
	logic osc_run_request;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [15:0] overlap_cnt, ov;
	wire [3:0] outs;
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;
	assign outs = {output_d, output_c, output_b, output_a};
	cdoc_top cdoc_top_inst
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.peripheral_sources, .internal_fast_oscillator, .shutdown_active,
		.output_a, .output_b, .output_c, .output_d, .osc_run_request
	);
	cdoc_switch_model cdoc_switch_model_inst
	(
		.aclk, .high_side(output_a), .low_side(output_b), .overlap_cnt
	);
	initial forever #50 aclk = ~aclk;
	// oscillator ticks every second clock
	always @(posedge aclk)
		internal_fast_oscillator <= ~internal_fast_oscillator;
	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (error_cnt == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			summarize();
		end
	end
	task automatic chk(input string w, input logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
			error_cnt++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk($sformatf("reg %h", a), e, d);
	endtask
	// drive the sources, count edges until output i turns on
	task automatic go(input logic [13:0] s, input int i, output int n);
		peripheral_sources <= s;
		n = 0;
		do
		begin
			@(posedge aclk);
			#1;
			n++;
		end
		while (outs[i] !== 1'b1 && n < 20);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		int n;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(`CDOC_OFS_CTRL, 32'h0);
		rchk(`CDOC_OFS_STATUS, 32'h0);
		rd(8'h20, d, r);
		chk("unmapped resp", {30'h0, `CDOC_RESP_DECERR}, {30'h0, r});
		chk("unmapped data", 32'h0, d);
		wr(`CDOC_OFS_DB_RISE, 8'h02);
		wr(`CDOC_OFS_DB_FALL, 8'h03);
		rchk(`CDOC_OFS_DB_RISE, 32'h2);
		wr(`CDOC_OFS_OVERRIDE, 8'h05);
		wr(`CDOC_OFS_CTRL, 8'h84);
		chk("outs at enable", 32'h0, {28'h0, outs});
		for (int k = 0; k < 14; k++)
		begin
			peripheral_sources <= 14'h1 << k;
			wr(`CDOC_OFS_SOURCE, k[7:0]);
			rd(`CDOC_OFS_STATUS, d, r);
			chk("selected input", 32'h10, d & 32'h10);
		end
		peripheral_sources <= 14'h0;
		wr(`CDOC_OFS_SOURCE, 8'h03);
		go(14'h0, 1, n);
		ov = overlap_cnt;
		go(14'h8, 0, n);
		chk("rise delay", 32'd4, n);
		chk("a over b", 32'h1, {30'h0, outs[1:0]});
		go(14'h0, 1, n);
		chk("fall delay", 32'd5, n);
		chk("b over a", 32'h2, {30'h0, outs[1:0]});
		peripheral_sources <= 14'h8;
		@(posedge aclk);
		go(14'h0, 0, n);
		chk("short pulse", 32'd20, n);
		chk("overlap", {16'h0, ov}, {16'h0, overlap_cnt});
		wr(`CDOC_OFS_DB_RISE, 8'h00);
		wr(`CDOC_OFS_CTRL, 8'hc4);
		go(14'h8, 0, n);
		chk("old rise delay", 32'd4, n);
		go(14'h0, 1, n);
		go(14'h8, 0, n);
		go(14'h0, 1, n);
		go(14'h8, 0, n);
		chk("new rise delay", 32'd1, n);
		rchk(`CDOC_OFS_CTRL, 32'h84);
		wr(`CDOC_OFS_POLARITY, 8'h01);
		@(posedge aclk);
		#1;
		chk("inverted a", 32'h0, {31'h0, output_a});
		wr(`CDOC_OFS_POLARITY, 8'h0f);
		shutdown_active <= 1'b1;
		repeat (3) @(posedge aclk);
		#1;
		chk("override", 32'h5, {28'h0, outs});
		shutdown_active <= 1'b0;
		wr(`CDOC_OFS_POLARITY, 8'h00);
		wr(`CDOC_OFS_CTRL, 8'h02);
		wr(`CDOC_OFS_DB_RISE, 8'h02);
		wr(`CDOC_OFS_CTRL, 8'h82);
		go(14'h0, 3, n);
		go(14'h8, 3, n);
		chk("forward outs", 32'h9, {28'h0, outs});
		wr(`CDOC_OFS_CTRL, 8'h83);
		go(14'h0, 3, n);
		go(14'h8, 1, n);
		chk("reverse delay", 32'd4, n);
		chk("reverse outs", 32'h6, {28'h0, outs});
		wr(`CDOC_OFS_CTRL, 8'h82);
		go(14'h0, 3, n);
		go(14'h8, 3, n);
		chk("forward delay", 32'd5, n);
		chk("forward outs", 32'h9, {28'h0, outs});
		wr(`CDOC_OFS_CLKSEL, 8'h01);
		wr(`CDOC_OFS_CTRL, 8'h04);
		wr(`CDOC_OFS_CTRL, 8'h84);
		go(14'h8, 0, n);
		go(14'h0, 1, n);
		chk("osc fall delay", 32'h1, {31'h0, n >= 7 && n <= 11});
		chk("osc request", 32'h1, {31'h0, osc_run_request});
		summarize();
	end
endmodule
`default_nettype wire
